// ==== hw/ibdp_pkg.sv ====
// Constants, codes and helpers for the instrument bus device port
package ibdp_pkg;
   // Timing
   localparam int CLK_NS = 5;
   localparam int SETTLE_NS = 2000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0] ADDR_CAP_CYC = 2'h3;
   localparam logic [4:0] ADDR_MAX = 5'h1E;
   localparam int SYNC_W = 20;
   // Bus commands sent under attention
   localparam logic [6:0] BC_GTL = 7'h01;
   localparam logic [6:0] BC_SDC = 7'h04;
   localparam logic [6:0] BC_GET = 7'h08;
   localparam logic [6:0] BC_DCL = 7'h14;
   localparam logic [6:0] BC_SPE = 7'h18;
   localparam logic [6:0] BC_SPD = 7'h19;
   localparam logic [6:0] BC_UNL = 7'h3F;
   localparam logic [1:0] BC_LAG = 2'h1;
   localparam logic [1:0] BC_TAG = 2'h2;
   // ASCII characters and two-letter codes
   localparam logic [6:0] ASC_0 = 7'h30;
   localparam logic [6:0] ASC_Z = 7'h5A;
   localparam logic [6:0] ASC_M = 7'h4D;
   localparam logic [6:0] ASC_G = 7'h47;
   localparam logic [6:0] ASC_K = 7'h4B;
   localparam logic [6:0] ASC_E = 7'h45;
   localparam logic [6:0] ASC_3 = 7'h33;
   localparam logic [6:0] ASC_CR = 7'h0D;
   localparam logic [6:0] ASC_LF = 7'h0A;
   localparam logic [13:0] CENTER_FREQ_CMD = 14'h21C6;
   localparam logic [13:0] SPAN_CMD = 14'h29D0;
   localparam logic [13:0] CENTER_STEP_UP_CMD = 14'h21D5;
   localparam logic [13:0] CENTER_STEP_DOWN_CMD = 14'h21C4;
   localparam logic [13:0] OUTPUT_VALUE_CMD = 14'h27D0;
   // Status byte bits
   localparam int STB_RQS = 6;
   localparam int STB_MAV = 4;
   // Frequencies in kHz
   localparam logic [31:0] CF_RST_KHZ = 32'h000F4240;
   localparam logic [31:0] SP_RST_KHZ = 32'h000F4240;
   localparam logic [31:0] CF_MAX_KHZ = 32'h003D0900;
   localparam logic [31:0] RES_WIDE_KHZ = 32'h000F4240;
   localparam logic [31:0] RES_MID_KHZ = 32'h00002710;
   localparam logic [31:0] RES_WIDE_MASK = 32'hFFFFFC00;
   localparam logic [31:0] RES_MID_MASK = 32'hFFFFFF80;
   localparam int STEP_SHIFT = 3;
   localparam logic [27:0] MUL_MEGA = 28'h00F4240;
   localparam logic [27:0] MUL_KILO = 28'h00003E8;
   localparam logic [27:0] MUL_ONE = 28'h0000001;
   localparam logic [3:0] FMT_DIGITS = 4'h8;
   localparam logic [3:0] FMT_LAST = 4'hB;

   function automatic logic ibdp_is_digit(input logic [6:0] c);
      return c >= ASC_0 && c <= 7'h39;
   endfunction : ibdp_is_digit

   function automatic logic ibdp_is_letter(input logic [6:0] c);
      return c >= 7'h41 && c <= ASC_Z;
   endfunction : ibdp_is_letter

   // Centre grid grows coarser with wider span
   function automatic logic [31:0] ibdp_quant(input logic [31:0] f, input logic [31:0] sp);
      if (sp >= RES_WIDE_KHZ) return f & RES_WIDE_MASK;
      if (sp >= RES_MID_KHZ) return f & RES_MID_MASK;
      return f;
   endfunction : ibdp_quant

   // Decimal weight of output digit position
   function automatic logic [31:0] ibdp_pow10(input logic [3:0] pos);
      case (pos)
         4'h0: return 32'h00989680;
         4'h1: return 32'h000F4240;
         4'h2: return 32'h000186A0;
         4'h3: return 32'h00002710;
         4'h4: return 32'h000003E8;
         4'h5: return 32'h00000064;
         4'h6: return 32'h0000000A;
         default: return 32'h00000001;
      endcase
   endfunction : ibdp_pow10
endpackage : ibdp_pkg

// ==== hw/ibdp_stream_if.sv ====
// Byte stream between bus handshake engines and the command core
`timescale 1ns/1ps
interface ibdp_stream_if;
   logic rx_valid;
   logic [7:0] rx_byte;
   logic rx_atn;
   logic tx_valid;
   logic [7:0] tx_byte;
   logic tx_eoi;
   logic tx_taken;
   modport acc (output rx_valid, output rx_byte, output rx_atn);
   modport src (input tx_valid, input tx_byte, input tx_eoi, output tx_taken);
   modport core (input rx_valid, input rx_byte, input rx_atn,
                 output tx_valid, output tx_byte, output tx_eoi, input tx_taken);
endinterface : ibdp_stream_if

// ==== hw/ibdp_acceptor.sv ====
// Acceptor handshake: takes bytes off the bus
`timescale 1ns/1ps
module ibdp_acceptor
   import ibdp_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Bus view, true logic
   input wire logic en,
   input wire logic atn_t,
   input wire logic dav_t,
   input wire logic [7:0] dio_t,
   // Handshake drives, high pulls line low
   output logic nrfd_r,
   output logic ndac_r,
   // Byte stream
   ibdp_stream_if.acc s
);
   typedef enum logic {A_READY, A_HOLD} ibdp_acc_t;
   ibdp_acc_t st_r;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // Accept on DAV, hold until DAV released
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r <= A_READY;
         nrfd_r <= 1'b0;
         ndac_r <= 1'b0;
         s.rx_valid <= 1'b0;
         s.rx_byte <= 8'h00;
         s.rx_atn <= 1'b0;
      end else begin
         s.rx_valid <= 1'b0;
         if (!en) begin
            st_r <= A_READY;
            nrfd_r <= 1'b0;
            ndac_r <= 1'b0;
         end else if (st_r == A_READY) begin
            nrfd_r <= dav_t;
            ndac_r <= !dav_t;
            if (dav_t) begin
               st_r <= A_HOLD;
               s.rx_valid <= 1'b1;
               s.rx_byte <= dio_t;
               s.rx_atn <= atn_t;
            end
         end else if (!dav_t) begin
            st_r <= A_READY;
            nrfd_r <= 1'b0;
            ndac_r <= 1'b1;
         end
      end
   end

   property p_acc_hold;
      s.rx_valid |-> nrfd_r && !ndac_r ##1 nrfd_r;
   endproperty
   a_acc_hold: assert property (p_acc_hold) else $error("byte taken without holding NRFD");
endmodule : ibdp_acceptor

// ==== hw/ibdp_source.sv ====
// Source handshake: puts talker bytes on the bus
`timescale 1ns/1ps
module ibdp_source
   import ibdp_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Bus view, true logic
   input wire logic en,
   input wire logic nrfd_t,
   input wire logic ndac_t,
   // Byte stream
   ibdp_stream_if.src s,
   // Line drives, true logic
   output logic [7:0] dio_r,
   output logic dav_r,
   output logic eoi_r
);
   typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_WAIT} ibdp_src_t;
   ibdp_src_t st_r;
   logic [8:0] cnt_r;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // Data settles before DAV, DAV held until accepted
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r <= S_IDLE;
         cnt_r <= 9'h000;
         dio_r <= 8'h00;
         dav_r <= 1'b0;
         eoi_r <= 1'b0;
         s.tx_taken <= 1'b0;
      end else begin
         s.tx_taken <= 1'b0;
         if (!en) begin
            st_r <= S_IDLE;
            dio_r <= 8'h00;
            dav_r <= 1'b0;
            eoi_r <= 1'b0;
         end else begin
            unique case (st_r)
               S_IDLE: if (s.tx_valid && !nrfd_t && !s.tx_taken) begin
                  st_r <= S_SETTLE;
                  cnt_r <= 9'h000;
                  dio_r <= s.tx_byte;
                  eoi_r <= s.tx_eoi;
               end
               S_SETTLE: begin
                  cnt_r <= cnt_r + 9'h001;
                  if (cnt_r == 9'(SETTLE_CYC - 1)) begin
                     st_r <= S_WAIT;
                     dav_r <= 1'b1;
                  end
               end
               S_WAIT: if (!ndac_t) begin
                  st_r <= S_IDLE;
                  dav_r <= 1'b0;
                  eoi_r <= 1'b0;
                  s.tx_taken <= 1'b1;
               end
            endcase
         end
      end
   end

   property p_src_stable;
      $rose(dav_r) |-> $stable(dio_r) && $past(st_r) == S_SETTLE;
   endproperty
   a_src_stable: assert property (p_src_stable) else $error("DAV raised on moving data");
endmodule : ibdp_source

// ==== hw/ibdp_top.sv ====
// Instrument bus device port: talker, listener, command parser
`timescale 1ns/1ps
module ibdp_top
   import ibdp_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Data lines, electrical level
   input wire logic [7:0] dio_in,
   output logic [7:0] dio_out,
   output logic [7:0] dio_oe,
   // Handshake lines
   input wire logic dav_in,
   output logic dav_out,
   output logic dav_oe,
   input wire logic nrfd_in,
   output logic nrfd_out,
   output logic nrfd_oe,
   input wire logic ndac_in,
   output logic ndac_out,
   output logic ndac_oe,
   // Control lines
   input wire logic eoi_in,
   output logic eoi_out,
   output logic eoi_oe,
   input wire logic srq_in,
   output logic srq_out,
   output logic srq_oe,
   input wire logic atn_in,
   input wire logic ifc_in,
   input wire logic ren_in,
   // Address switch
   input wire logic [4:0] addr_sw,
   // Instrument side
   input wire logic service_req,
   input wire logic plotter_active,
   output logic [31:0] center_khz,
   output logic [31:0] span_khz,
   output logic trigger,
   output logic dev_clear,
   output logic remote,
   output logic ctrl_enable
);
   typedef enum logic [2:0] {P_IDLE, P_LET2, P_NUM, P_UNIT, P_SEL1, P_SEL2} ibdp_parse_t;

   ibdp_stream_if bs ();
   logic [SYNC_W-1:0] sy1_r, sy2_r;
   logic [1:0] cap_cnt_r;
   logic addr_done_r;
   logic [4:0] my_addr_r;
   logic lad_r, tad_r, spms_r, srq_pend_r;
   ibdp_parse_t pst_r;
   logic [6:0] first_r;
   logic tgt_r;
   logic [19:0] num_r;
   logic fmt_on_r, tx_valid_r, tx_eoi_r;
   logic [3:0] fmt_pos_r, fmt_dig_r;
   logic [31:0] fmt_rem_r;
   logic [7:0] tx_byte_r;
   logic acc_nrfd, acc_ndac, src_dav, src_eoi;
   logic [7:0] src_dio;

   // Two-stage synchroniser for every bus pin except SRQ
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sy1_r <= {SYNC_W{1'b1}}; // Idle bus is high, no false DAV or ATN
         sy2_r <= {SYNC_W{1'b1}};
      end else begin
         sy1_r <= {dio_in, dav_in, nrfd_in, ndac_in, eoi_in, atn_in, ifc_in, ren_in, addr_sw};
         sy2_r <= sy1_r;
      end
   end

   // Low level on the bus means true
   wire [7:0] dio_t = ~sy2_r[19:12];
   wire dav_t = !sy2_r[11];
   wire nrfd_t = !sy2_r[10];
   wire ndac_t = !sy2_r[9];
   wire atn_t = !sy2_r[7];
   wire ifc_t = !sy2_r[6];
   wire ren_t = !sy2_r[5];
   wire [4:0] sw_s = sy2_r[4:0];

   // Address caught once, after synchroniser fills
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cap_cnt_r <= 2'h0;
         addr_done_r <= 1'b0;
         my_addr_r <= 5'h00;
      end else if (!addr_done_r) begin
         cap_cnt_r <= cap_cnt_r + 2'h1;
         if (cap_cnt_r == ADDR_CAP_CYC) begin
            my_addr_r <= sw_s;
            addr_done_r <= 1'b1;
         end
      end
   end

   // Bus command decode under attention
   wire addr_ok = addr_done_r && my_addr_r <= ADDR_MAX;
   wire cmd = bs.rx_valid && bs.rx_atn;
   wire [6:0] b7 = bs.rx_byte[6:0];
   wire is_mla = cmd && addr_ok && b7 == {BC_LAG, my_addr_r};
   wire is_mta = cmd && addr_ok && b7 == {BC_TAG, my_addr_r};
   wire is_otad = cmd && b7[6:5] == BC_TAG && !is_mta;
   wire is_unl = cmd && b7 == BC_UNL;
   wire is_dcl = cmd && (b7 == BC_DCL || (b7 == BC_SDC && lad_r));
   wire is_get = cmd && b7 == BC_GET && lad_r;
   wire is_gtl = cmd && b7 == BC_GTL && lad_r;
   wire is_spe = cmd && b7 == BC_SPE;
   wire is_spd = cmd && b7 == BC_SPD;

   // Addressing state; parallel poll bytes fall through unused
   wire lad_nxt = ifc_t ? 1'b0 : is_mla ? 1'b1 : (is_unl || is_mta) ? 1'b0 : lad_r;
   wire tad_nxt = ifc_t ? 1'b0 : is_mta ? 1'b1 : (is_otad || is_mla) ? 1'b0 : tad_r;
   wire spms_nxt = ifc_t ? 1'b0 : is_spe ? 1'b1 : is_spd ? 1'b0 : spms_r;
   wire remote_nxt = !ren_t ? 1'b0 : is_mla ? 1'b1 : is_gtl ? 1'b0 : remote;

   // Serial poll answer and service request
   wire sp_mode = spms_r && tad_r;
   wire sp_taken = sp_mode && bs.tx_taken;
   wire srq_nxt = service_req || (srq_pend_r && !sp_taken && !is_dcl);
   wire [7:0] stb = {1'b0, srq_pend_r, 1'b0, fmt_on_r || tx_valid_r, 4'h0};
   assign bs.tx_valid = sp_mode || tx_valid_r;
   assign bs.tx_byte = sp_mode ? stb : tx_byte_r;
   assign bs.tx_eoi = sp_mode ? 1'b0 : tx_eoi_r;
   wire fmt_taken = !sp_mode && bs.tx_taken;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lad_r <= 1'b0;
         tad_r <= 1'b0;
         spms_r <= 1'b0;
         remote <= 1'b0;
         srq_pend_r <= 1'b0;
         trigger <= 1'b0;
         dev_clear <= 1'b0;
         ctrl_enable <= 1'b0;
      end else begin
         lad_r <= lad_nxt;
         tad_r <= tad_nxt;
         spms_r <= spms_nxt;
         remote <= remote_nxt;
         srq_pend_r <= srq_nxt;
         trigger <= is_get;
         dev_clear <= is_dcl;
         ctrl_enable <= plotter_active;
      end
   end

   // Device-dependent ASCII parser
   wire dat = bs.rx_valid && !bs.rx_atn && lad_r;
   wire [6:0] ch = bs.rx_byte[6:0];
   wire [13:0] pair = {first_r, ch};
   wire do_cu = dat && pst_r == P_LET2 && pair == CENTER_STEP_UP_CMD;
   wire do_cd = dat && pst_r == P_LET2 && pair == CENTER_STEP_DOWN_CMD;
   wire [27:0] unit_mul = first_r == ASC_G ? MUL_MEGA : first_r == ASC_M ? MUL_KILO : MUL_ONE;
   wire unit_ok = first_r == ASC_G || first_r == ASC_M || first_r == ASC_K;
   wire do_set = dat && pst_r == P_UNIT && ch == ASC_Z && unit_ok;
   wire sel_cf = pair == CENTER_FREQ_CMD;
   wire do_op = dat && pst_r == P_SEL2 && (sel_cf || pair == SPAN_CMD);
   wire [47:0] prod = num_r * unit_mul;
   wire [31:0] val_khz = prod > 48'(CF_MAX_KHZ) ? CF_MAX_KHZ : prod[31:0];
   wire [31:0] step_raw = span_khz >> STEP_SHIFT;
   wire [31:0] step = step_raw == 32'h0 ? 32'h1 : step_raw;
   wire [32:0] up_sum = {1'b0, center_khz} + {1'b0, step};
   wire [31:0] up_val = up_sum > 33'(CF_MAX_KHZ) ? CF_MAX_KHZ : up_sum[31:0];
   wire [31:0] dn_val = center_khz > step ? center_khz - step : 32'h0;
   wire [19:0] num_x10 = 20'(num_r * 20'hA) + 20'(ch - ASC_0);

   // Parser states follow arrival order of characters
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pst_r <= P_IDLE;
         first_r <= 7'h00;
         tgt_r <= 1'b0;
         num_r <= 20'h00000;
      end else if (is_dcl) begin
         pst_r <= P_IDLE;
      end else if (dat) begin
         unique case (pst_r)
            P_IDLE, P_SEL1: if (ibdp_is_letter(ch)) begin
               first_r <= ch;
               pst_r <= pst_r == P_SEL1 ? P_SEL2 : P_LET2;
            end
            P_LET2: begin
               tgt_r <= pair == SPAN_CMD;
               num_r <= 20'h00000;
               if (pair == CENTER_FREQ_CMD || pair == SPAN_CMD) pst_r <= P_NUM;
               else if (pair == OUTPUT_VALUE_CMD) pst_r <= P_SEL1;
               else pst_r <= P_IDLE;
            end
            P_NUM: begin
               if (ibdp_is_digit(ch) && num_r < 20'h19999) num_r <= num_x10;
               else if (ibdp_is_letter(ch)) begin
                  first_r <= ch;
                  pst_r <= P_UNIT;
               end
            end
            P_UNIT, P_SEL2: pst_r <= P_IDLE;
         endcase
      end
   end

   // Centre and span settings
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         center_khz <= CF_RST_KHZ;
         span_khz <= SP_RST_KHZ;
      end else if (do_set && tgt_r) begin
         span_khz <= val_khz == 32'h0 ? 32'h1 : val_khz;
      end else if (do_set) begin
         center_khz <= ibdp_quant(val_khz, span_khz);
      end else if (do_cu) begin
         center_khz <= ibdp_quant(up_val, span_khz);
      end else if (do_cd) begin
         center_khz <= ibdp_quant(dn_val, span_khz);
      end
   end

   // Decimal kHz answer: eight digits, E3, CR, LF with EOI
   wire [31:0] pw = ibdp_pow10(fmt_pos_r);
   wire fmt_step = fmt_on_r && !tx_valid_r;
   wire fmt_digit = fmt_pos_r < FMT_DIGITS;
   wire fmt_sub = fmt_step && fmt_digit && fmt_rem_r >= pw;
   wire [6:0] tail = fmt_pos_r == 4'h8 ? ASC_E : fmt_pos_r == 4'h9 ? ASC_3 :
                     fmt_pos_r == 4'hA ? ASC_CR : ASC_LF;
   wire [6:0] fmt_ch = fmt_digit ? ASC_0 + {3'h0, fmt_dig_r} : tail;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fmt_on_r <= 1'b0;
         fmt_pos_r <= 4'h0;
         fmt_dig_r <= 4'h0;
         fmt_rem_r <= 32'h0;
         tx_valid_r <= 1'b0;
         tx_byte_r <= 8'h00;
         tx_eoi_r <= 1'b0;
      end else if (is_dcl) begin
         fmt_on_r <= 1'b0;
         tx_valid_r <= 1'b0;
      end else if (do_op) begin
         fmt_on_r <= 1'b1;
         fmt_pos_r <= 4'h0;
         fmt_dig_r <= 4'h0;
         fmt_rem_r <= sel_cf ? center_khz : span_khz;
         tx_valid_r <= 1'b0;
      end else begin
         if (fmt_taken) tx_valid_r <= 1'b0;
         if (fmt_sub) begin
            fmt_rem_r <= fmt_rem_r - pw;
            fmt_dig_r <= fmt_dig_r + 4'h1;
         end else if (fmt_step) begin
            tx_byte_r <= {1'b0, fmt_ch};
            tx_eoi_r <= fmt_pos_r == FMT_LAST;
            tx_valid_r <= 1'b1;
            fmt_dig_r <= 4'h0;
            fmt_pos_r <= fmt_pos_r + 4'h1;
            fmt_on_r <= fmt_pos_r != FMT_LAST;
         end
      end
   end

   // Handshake engines
   ibdp_acceptor u_acc (
      .clock(clock),
      .rst(rst),
      .en(atn_t || lad_r),
      .atn_t(atn_t),
      .dav_t(dav_t),
      .dio_t(dio_t),
      .nrfd_r(acc_nrfd),
      .ndac_r(acc_ndac),
      .s(bs.acc)
   );

   ibdp_source u_src (
      .clock(clock),
      .rst(rst),
      .en(tad_r && !atn_t),
      .nrfd_t(nrfd_t),
      .ndac_t(ndac_t),
      .s(bs.src),
      .dio_r(src_dio),
      .dav_r(src_dav),
      .eoi_r(src_eoi)
   );

   // Pin drivers: DAV, EOI three-state, rest pull low only
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dio_out <= 8'h00;
         dio_oe <= 8'h00;
         dav_out <= 1'b1;
         dav_oe <= 1'b0;
         eoi_out <= 1'b1;
         eoi_oe <= 1'b0;
         nrfd_out <= 1'b0;
         nrfd_oe <= 1'b0;
         ndac_out <= 1'b0;
         ndac_oe <= 1'b0;
         srq_out <= 1'b0;
         srq_oe <= 1'b0;
      end else begin
         dio_oe <= src_dio;
         dav_oe <= tad_r && !atn_t;
         dav_out <= !src_dav;
         eoi_oe <= tad_r && !atn_t;
         eoi_out <= !src_eoi;
         nrfd_oe <= acc_nrfd;
         ndac_oe <= acc_ndac;
         srq_oe <= srq_pend_r;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_talk_drop;
      is_mla && !ifc_t |=> lad_r && !tad_r;
   endproperty
   a_talk_drop: assert property (p_talk_drop) else $error("talker kept after listen address");
   property p_listen_drop;
      is_mta && !ifc_t |=> tad_r && !lad_r;
   endproperty
   a_listen_drop: assert property (p_listen_drop) else $error("listener kept after talk address");
   property p_no_ppoll;
      atn_t [*3] |-> dio_oe == 8'h00 && !eoi_oe;
   endproperty
   a_no_ppoll: assert property (p_no_ppoll) else $error("bus driven under attention");
   property p_clear;
      is_dcl |=> dev_clear && !fmt_on_r && !tx_valid_r && pst_r == P_IDLE;
   endproperty
   a_clear: assert property (p_clear) else $error("device clear not applied");
   property p_trig;
      is_get |=> trigger ##1 !trigger || $past(is_get);
   endproperty
   a_trig: assert property (p_trig) else $error("trigger pulse missing");
   property p_three_state;
      atn_t |=> !dav_oe && !eoi_oe;
   endproperty
   a_three_state: assert property (p_three_state) else $error("DAV or EOI driven under attention");
   property p_addr_hold;
      addr_done_r |=> addr_done_r && $stable(my_addr_r);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address changed after capture");
   property p_step_down;
      do_cd |=> center_khz <= $past(center_khz);
   endproperty
   a_step_down: assert property (p_step_down) else $error("step down raised centre");
   property p_step_up;
      do_cu && center_khz < RES_MID_MASK && up_sum <= 33'(CF_MAX_KHZ) |=> center_khz > $past(center_khz);
   endproperty
   a_step_up: assert property (p_step_up) else $error("step up did not raise centre");
   property p_srq;
      service_req |=> ##1 srq_oe;
   endproperty
   a_srq: assert property (p_srq) else $error("service request not driven");
   property p_remote;
      !ren_t |=> !remote;
   endproperty
   a_remote: assert property (p_remote) else $error("remote held without enable");
endmodule : ibdp_top

// ==== dv/ibdp_ctrl_model.sv ====
// Bus controller model: sources and accepts bytes on the handshake lines
`timescale 1ns/1ps
module ibdp_ctrl_model (
   // Clock
   input wire logic clock,
   // Device drives
   input wire logic [7:0] dio_oe,
   input wire logic dav_out,
   input wire logic dav_oe,
   input wire logic nrfd_oe,
   input wire logic ndac_oe,
   // Line levels, low means true
   output logic [7:0] dio_in,
   output logic dav_in,
   output logic nrfd_in,
   output logic ndac_in,
   output logic atn_in
);
   logic [7:0] d = 8'h00;
   logic dav = 1'b0;
   logic ndac = 1'b0;
   logic atn = 1'b0;
   // Wired levels; released lines float high by pull-up
   assign dio_in = ~(d | dio_oe);
   assign dav_in = dav_oe ? dav_out : ~dav;
   assign nrfd_in = ~nrfd_oe;
   assign ndac_in = ~(ndac | ndac_oe);
   assign atn_in = ~atn;
   // Source one byte with the three-wire handshake
   task automatic send(input logic a, input logic [7:0] b);
      int n;
      n = 0;
      @(negedge clock);
      atn = a;
      // Acceptor must be ready and holding NDAC before DAV goes true
      while (!(nrfd_in && !ndac_in) && n < 900) begin @(negedge clock); n++; end
      d = b;
      @(negedge clock);
      dav = 1'b1;
      while (!ndac_in && n < 900) begin @(negedge clock); n++; end
      dav = 1'b0;
      d = 8'h00;
   endtask : send
   // Accept one byte from the talking device
   task automatic take(output logic [7:0] b);
      int n;
      n = 0;
      @(negedge clock);
      atn = 1'b0;
      ndac = 1'b1;
      while (dav_in && n < 900) begin @(negedge clock); n++; end
      b = ~dio_in;
      ndac = 1'b0;
      while (!dav_in && n < 900) begin @(negedge clock); n++; end
   endtask : take
endmodule : ibdp_ctrl_model

// ==== dv/ibdp_top_bench.sv ====
// Self-checking bench for the instrument bus device port
`timescale 1ns/1ps
module ibdp_top_bench;
   import ibdp_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic ren_in = 1'b0;
   logic [4:0] addr_sw = 5'h05;
   logic service_req = 1'b0;
   logic plotter_active = 1'b0;
   logic [7:0] dio_in, dio_oe;
   logic dav_in, dav_out, dav_oe, nrfd_in, nrfd_oe, ndac_in, ndac_oe, atn_in;
   logic eoi_out, eoi_oe, srq_oe, trigger, dev_clear, remote, ctrl_enable;
   logic [7:0] eoi_b = 8'h00;
   logic [31:0] center_khz, span_khz;
   int failures = 0;
   int checks = 0;
   int cyc = 0;
   int trig_n = 0;
   int clr_n = 0;
   // Design and controller model
   ibdp_top ibdp_top_inst (.clock, .rst, .dio_in, .dio_out(), .dio_oe, .dav_in, .dav_out,
      .dav_oe, .nrfd_in, .nrfd_out(), .nrfd_oe, .ndac_in, .ndac_out(), .ndac_oe,
      .eoi_in(1'b1), .eoi_out, .eoi_oe, .srq_in(1'b1), .srq_out(), .srq_oe, .atn_in,
      .ifc_in(1'b1), .ren_in, .addr_sw, .service_req, .plotter_active, .center_khz,
      .span_khz, .trigger, .dev_clear, .remote, .ctrl_enable);
   ibdp_ctrl_model ibdp_ctrl_model_inst (.clock, .dio_oe, .dav_out, .dav_oe, .nrfd_oe,
      .ndac_oe, .dio_in, .dav_in, .nrfd_in, .ndac_in, .atn_in);
   // Clock, pulse counters and hang guard
   initial forever #2.5 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (trigger === 1'b1) trig_n++;
      if (dev_clear === 1'b1) clr_n++;
      // First byte that the talker marks with EOI
      if (dav_oe === 1'b1 && dav_out === 1'b0 && eoi_out === 1'b0 && eoi_b == 8'h00)
         eoi_b = dio_oe;
      if (cyc == 80000) begin failures++; stop_test(); end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic str(input string s);
      foreach (s[i]) ibdp_ctrl_model_inst.send(1'b0, s[i]);
      repeat (4) @(negedge clock);
   endtask : str
   task automatic t_settings();
      ibdp_ctrl_model_inst.send(1'b1, {1'b0, BC_LAG, addr_sw});
      repeat (4) @(negedge clock);
      chk("remote", 1, remote);
      str("SP2MZ");
      chk("span", 2000, span_khz);
      str("CF500MZ");
      chk("center", 500000, center_khz);
      str("CU");
      chk("center up", 500250, center_khz);
      str("CD");
      chk("center down", 500000, center_khz);
      str("SP1GZ");
      chk("span g", 1000000, span_khz);
      str("CF1234MZ");
      chk("center q", 32'd1234000 & 32'hFFFFFC00, center_khz);
   endtask : t_settings
   task automatic t_events();
      ibdp_ctrl_model_inst.send(1'b1, {1'b0, BC_GET});
      ibdp_ctrl_model_inst.send(1'b1, {1'b0, BC_DCL});
      repeat (4) @(negedge clock);
      chk("trigger", 1, trig_n);
      chk("clear", 1, clr_n);
   endtask : t_events
   task automatic t_talk();
      string s;
      logic [7:0] b;
      s = $sformatf("%08dE3\r\n", 32'd1234000 & 32'hFFFFFC00);
      str("OPCF");
      ibdp_ctrl_model_inst.send(1'b1, {1'b0, BC_TAG, addr_sw});
      foreach (s[i]) begin
         ibdp_ctrl_model_inst.take(b);
         chk("answer", s[i], b);
      end
      chk("eoi byte", 8'h0A, eoi_b);
      ibdp_ctrl_model_inst.send(1'b1, {1'b0, BC_LAG, addr_sw});
      str("\n");
      chk("talk drive", 0, dav_oe);
   endtask : t_talk
   task automatic t_side();
      service_req = 1'b1;
      plotter_active = 1'b1;
      @(negedge clock);
      service_req = 1'b0;
      repeat (3) @(negedge clock);
      chk("srq", 1, srq_oe);
      chk("ctrl", 1, ctrl_enable);
   endtask : t_side
   task automatic stop_test();
      if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   // Main sequence
   initial begin
      repeat (10) @(negedge clock);
      chk("reset center", CF_RST_KHZ, center_khz);
      chk("reset oe", 0, {dio_oe, dav_oe, eoi_oe});
      rst = 1'b0;
      repeat (8) @(negedge clock);
      t_settings();
      t_events();
      t_talk();
      t_side();
      stop_test();
   end
endmodule : ibdp_top_bench
